/* verilog/fsb_host.sv */
// host-side flash sequencer: bypass program, sector protect and status polling over apb
// Overview of operation
// - in bypass a program takes two bus writes instead of four.
// - bypass lasts until the bypass exit command; normal reads follow exit. The host's bypass flag also clears on presetn.
// - host never issues an erase while bypass is active.
// - bypass program is program setup code then one location/value write.
// - protect with high voltage on reset pin: 60h, then 60h at sector with 0,1,0.
// - verify with 60h; bit 0 high means protected, else repeat protect.
// - host ends protection by returning reset pin to normal high.
// - erase polling only after sixth write strobe, inside an erased sector.
// - data taken only from a read after status ended.
// - non-blank program locks; failure bit rises; host writes reset command.
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/100ps
module fsb_host #(
  parameter int                        PROT_CYC   = fsb_pkg::PROT_CYC,
  parameter int                        PROT_TRIES = fsb_pkg::PROT_TRIES,
  parameter logic [fsb_pkg::ADDR_W-1:0] UNLK_ADDR1 = 20'h00555,
  parameter logic [fsb_pkg::ADDR_W-1:0] UNLK_ADDR2 = 20'h002aa,
  parameter logic [7:0]                UNLK_DATA1 = 8'haa,
  parameter logic [7:0]                UNLK_DATA2 = 8'h55,
  parameter logic [7:0]                CMD_ESETUP = 8'h80,
  parameter logic [7:0]                CMD_CHIP   = 8'h10,
  parameter logic [7:0]                CMD_SECTOR = 8'h30,
  parameter logic [7:0]                CMD_BYP_IN = 8'h20,
  parameter logic [7:0]                CMD_BYP_X1 = 8'h90,
  parameter logic [7:0]                CMD_BYP_X2 = 8'h00,
  parameter logic [7:0]                CMD_RESET  = 8'hf0
) (
  // clock and reset
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  // apb slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [fsb_pkg::PADDR_W-1:0]  paddr,
  input  wire logic [31:0]                  pwdata,
  output logic [31:0]                       prdata_r,
  output logic                              pready_r,
  output logic                              pslverr_r,
  // flash pins
  output fsb_pkg::fsb_pins_s                pins_r,
  input  wire logic [7:0]                   dq_i,
  output logic                              hv_en_r
);
  import fsb_pkg::*;

  typedef enum logic [1:0] {S_IDLE = 2'b00, S_ISSUE = 2'b01, S_WAIT = 2'b10, S_PAUSE = 2'b11} fsb_st_e;
  typedef enum logic [2:0] {
    PH_SEQ = 3'b000, PH_POLL1 = 3'b001, PH_POLL2 = 3'b010,
    PH_FINAL = 3'b011, PH_VERIFY = 3'b100, PH_RESET = 3'b101
  } fsb_ph_e;
  localparam int TW = $clog2(PROT_CYC + 1);

  fsb_st_e           st_r;
  fsb_ph_e           ph_r;
  fsb_op_e           op_r;
  fsb_req_s          req_r;
  logic              req_v_r;
  logic [2:0]        idx_r;
  logic [TW-1:0]     tmr_r;
  logic [7:0]        tries_r;
  logic              tgl_r;
  logic              rechk_r;
  logic              busy_r;
  logic              bypass_r;
  logic              fail_r;
  logic              refused_r;
  logic              prot_ok_r;
  logic [7:0]        rdata_r;
  logic [7:0]        stat_r;
  logic [ADDR_W-1:0] addr_r;
  logic [7:0]        wdata_r;
  logic              bdone;
  logic [7:0]        brd;

  function automatic logic [2:0] seq_len(input fsb_op_e op, input logic byp);
    case (op)
      OP_PROG:                      seq_len = byp ? 3'd2 : 3'd4;
      OP_BYP_ENTER, OP_PROTECT:     seq_len = 3'd3;
      OP_BYP_EXIT:                  seq_len = 3'd2;
      OP_SECT_ERASE, OP_CHIP_ERASE: seq_len = 3'd6;
      OP_WRITE, OP_RESET:           seq_len = 3'd1;
      default:                      seq_len = 3'd0;
    endcase
  endfunction

  function automatic fsb_req_s seq_word(input fsb_op_e op, input logic [2:0] idx, input logic byp,
                                        input logic [ADDR_W-1:0] a, input logic [7:0] d);
    fsb_req_s r;
    r = '{1'b1, a, d};
    case (op)
      OP_PROG:
        if (byp)
        begin
          if (idx == 3'd0)
            r.data = CMD_PROG;
        end
        else
          case (idx)
            3'd0:    r = '{1'b1, UNLK_ADDR1, UNLK_DATA1};
            3'd1:    r = '{1'b1, UNLK_ADDR2, UNLK_DATA2};
            3'd2:    r = '{1'b1, UNLK_ADDR1, CMD_PROG};
            default: r = '{1'b1, a, d};
          endcase
      OP_BYP_ENTER:
        case (idx)
          3'd0:    r = '{1'b1, UNLK_ADDR1, UNLK_DATA1};
          3'd1:    r = '{1'b1, UNLK_ADDR2, UNLK_DATA2};
          default: r = '{1'b1, UNLK_ADDR1, CMD_BYP_IN};
        endcase
      OP_BYP_EXIT:
        r.data = (idx == 3'd0) ? CMD_BYP_X1 : CMD_BYP_X2;
      OP_SECT_ERASE, OP_CHIP_ERASE:
        case (idx)
          3'd0, 3'd3: r = '{1'b1, UNLK_ADDR1, UNLK_DATA1};
          3'd1, 3'd4: r = '{1'b1, UNLK_ADDR2, UNLK_DATA2};
          3'd2:       r = '{1'b1, UNLK_ADDR1, CMD_ESETUP};
          default:    r = (op == OP_CHIP_ERASE) ? '{1'b1, UNLK_ADDR1, CMD_CHIP} : '{1'b1, a, CMD_SECTOR};
        endcase
      OP_PROTECT:
        r = (idx == 3'd0) ? '{1'b1, a, CMD_PROTECT} : '{1'b1, {a[ADDR_W-1:12], PROT_LOW}, CMD_PROTECT};
      OP_RESET:
        r.data = CMD_RESET;
      default:
        r = '{1'b1, a, d};
    endcase
    return r;
  endfunction

  logic    acc;
  logic    start;
  fsb_op_e cmd_op;
  logic    erase_req;
  logic    seq_end;
  logic    toggled;
  logic    fail_set;
  logic    ok_set;
  assign acc       = psel && penable && pready_r;
  assign start     = acc && pwrite && (paddr == REG_CMD);
  assign cmd_op    = fsb_op_e'(pwdata[3:0]);
  assign erase_req = (cmd_op == OP_SECT_ERASE) || (cmd_op == OP_CHIP_ERASE);
  assign seq_end   = (st_r == S_WAIT) && bdone && (ph_r == PH_SEQ) && (idx_r + 3'd1 == seq_len(op_r, bypass_r));
  assign toggled   = brd[6] != tgl_r;
  assign fail_set  = (st_r == S_WAIT) && bdone && ((ph_r == PH_POLL2 && toggled && brd[5] && rechk_r)
                     || (ph_r == PH_VERIFY && !brd[0] && tries_r == 8'(PROT_TRIES - 1)));
  assign ok_set    = (st_r == S_WAIT) && bdone && (ph_r == PH_VERIFY) && brd[0];

  fsb_bus_cycle u_cycle (
    .pclk      (pclk),
    .presetn   (presetn),
    .req_valid (req_v_r),
    .req       (req_r),
    .done_r    (bdone),
    .rdata_r   (brd),
    .pins_r    (pins_r),
    .dq_i      (dq_i)
  );

  // zero-wait apb answer prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end
    else if (psel && !penable)
    begin
      pready_r  <= 1'b1;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
      case (paddr)
        REG_CMD:    prdata_r <= {28'h0000000, op_r};
        REG_ADDR:   prdata_r <= {12'h000, addr_r};
        REG_WDATA:  prdata_r <= {24'h000000, wdata_r};
        REG_STATUS: prdata_r <= {16'h0000, stat_r, 2'b00, hv_en_r, prot_ok_r, refused_r, fail_r, bypass_r, busy_r};
        REG_RDATA:  prdata_r <= {24'h000000, rdata_r};
        default:    pslverr_r <= !pwrite || 1'b1;
      endcase
    end
    else
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      addr_r  <= 20'h00000;
      wdata_r <= 8'h00;
    end
    else if (acc && pwrite && !pslverr_r)
    begin
      if (paddr == REG_ADDR)
        addr_r <= pwdata[ADDR_W-1:0];
      if (paddr == REG_WDATA)
        wdata_r <= pwdata[7:0];
    end
  end

  // sticky result flags; a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fail_r    <= 1'b0;
      prot_ok_r <= 1'b0;
      refused_r <= 1'b0;
    end
    else
    begin
      if (start && !busy_r)
      begin
        fail_r    <= 1'b0;
        prot_ok_r <= 1'b0;
        refused_r <= erase_req && bypass_r;
      end
      else if (start)
        refused_r <= 1'b1;
      if (fail_set)
        fail_r <= 1'b1;
      if (ok_set)
        prot_ok_r <= 1'b1;
    end
  end

  // cleared by presetn so programming falls back to the four-write form
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      bypass_r <= 1'b0;
    else if (seq_end && op_r == OP_BYP_ENTER)
      bypass_r <= 1'b1;
    else if (seq_end && op_r == OP_BYP_EXIT)
      bypass_r <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stat_r <= 8'h00;
    else if (st_r == S_WAIT && bdone && ph_r != PH_SEQ && ph_r != PH_RESET)
      stat_r <= brd;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r    <= S_IDLE;
      ph_r    <= PH_SEQ;
      op_r    <= OP_NONE;
      req_r   <= '{1'b0, 20'h00000, 8'h00};
      req_v_r <= 1'b0;
      idx_r   <= 3'd0;
      tmr_r   <= '0;
      tries_r <= 8'h00;
      tgl_r   <= 1'b0;
      rechk_r <= 1'b0;
      busy_r  <= 1'b0;
      hv_en_r <= 1'b0;
      rdata_r <= 8'h00;
    end
    else
    begin
      req_v_r <= 1'b0;
      case (st_r)
        S_IDLE:
          if (start && !(erase_req && bypass_r) && cmd_op != OP_NONE && seq_len(cmd_op, bypass_r) != 3'd0
              || start && cmd_op == OP_READ)
          begin
            op_r    <= cmd_op;
            busy_r  <= 1'b1;
            idx_r   <= 3'd0;
            tries_r <= 8'h00;
            rechk_r <= 1'b0;
            hv_en_r <= cmd_op == OP_PROTECT;
            ph_r    <= (cmd_op == OP_READ) ? PH_FINAL : PH_SEQ;
            req_r   <= (cmd_op == OP_READ) ? '{1'b0, addr_r, 8'h00} : seq_word(cmd_op, 3'd0, bypass_r, addr_r, wdata_r);
            st_r    <= S_ISSUE;
          end
        S_ISSUE:
        begin
          req_v_r <= 1'b1;
          st_r    <= S_WAIT;
        end
        S_PAUSE:
          if (tmr_r == '0)
            st_r <= S_ISSUE;
          else
            tmr_r <= tmr_r - 1'b1;
        S_WAIT:
          if (bdone)
          begin
            st_r <= S_ISSUE;
            case (ph_r)
              PH_SEQ:
                if (op_r == OP_PROTECT && idx_r == 3'd1)
                begin
                  idx_r <= 3'd2;
                  req_r <= seq_word(op_r, 3'd2, bypass_r, addr_r, wdata_r);
                  tmr_r <= TW'(PROT_CYC);
                  st_r  <= S_PAUSE;
                end
                else if (!seq_end)
                begin
                  idx_r <= idx_r + 3'd1;
                  req_r <= seq_word(op_r, idx_r + 3'd1, bypass_r, addr_r, wdata_r);
                end
                else if (op_r == OP_PROG || op_r == OP_SECT_ERASE || op_r == OP_CHIP_ERASE)
                begin
                  // first poll after the last write strobe, at the target location
                  ph_r  <= PH_POLL1;
                  req_r <= '{1'b0, addr_r, 8'h00};
                end
                else if (op_r == OP_PROTECT)
                begin
                  ph_r  <= PH_VERIFY;
                  req_r <= '{1'b0, {addr_r[ADDR_W-1:12], PROT_LOW}, 8'h00};
                end
                else
                begin
                  busy_r <= 1'b0;
                  st_r   <= S_IDLE;
                end
              PH_POLL1:
              begin
                tgl_r <= brd[6];
                ph_r  <= PH_POLL2;
              end
              PH_POLL2:
                if (!toggled)
                  ph_r <= PH_FINAL;
                else if (brd[5] && rechk_r)
                begin
                  ph_r  <= PH_RESET;
                  req_r <= '{1'b1, addr_r, CMD_RESET};
                end
                else
                begin
                  rechk_r <= brd[5];
                  ph_r    <= PH_POLL1;
                end
              PH_FINAL:
              begin
                rdata_r <= brd;
                busy_r  <= 1'b0;
                st_r    <= S_IDLE;
              end
              PH_VERIFY:
                if (brd[0] || tries_r == 8'(PROT_TRIES - 1))
                begin
                  hv_en_r <= 1'b0;
                  busy_r  <= 1'b0;
                  st_r    <= S_IDLE;
                end
                else
                begin
                  tries_r <= tries_r + 8'h01;
                  ph_r    <= PH_SEQ;
                  idx_r   <= 3'd1;
                  req_r   <= seq_word(op_r, 3'd1, bypass_r, addr_r, wdata_r);
                end
              default:
              begin
                busy_r  <= 1'b0;
                hv_en_r <= 1'b0;
                st_r    <= S_IDLE;
              end
            endcase
          end
        default:
          st_r <= S_IDLE;
      endcase
    end
  end

  // write strobes seen on the pins during one operation
  logic       we_q_r;
  logic [3:0] wr_cnt_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      we_q_r   <= 1'b1;
      wr_cnt_r <= 4'h0;
    end
    else
    begin
      we_q_r <= pins_r.we_n;
      if (st_r == S_IDLE)
        wr_cnt_r <= 4'h0;
      else if (we_q_r && !pins_r.we_n)
        wr_cnt_r <= wr_cnt_r + 4'h1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_prog_len;
    seq_end && op_r == OP_PROG |-> wr_cnt_r == (bypass_r ? 4'h2 : 4'h4);
  endproperty
  a_prog_len: assert property (p_prog_len) else $error("program write count wrong");

  property p_exit_only;
    $fell(bypass_r) |-> $past(op_r) == OP_BYP_EXIT && $past(seq_end);
  endproperty
  a_exit_only: assert property (p_exit_only) else $error("bypass left without exit");

  property p_no_erase_byp;
    start && st_r == S_IDLE && erase_req && bypass_r |=> refused_r && st_r == S_IDLE ##1 !busy_r;
  endproperty
  a_no_erase_byp: assert property (p_no_erase_byp) else $error("erase issued in bypass");

  property p_byp_setup;
    req_v_r && bypass_r && op_r == OP_PROG && ph_r == PH_SEQ && idx_r == 3'd0 |-> req_r.data == CMD_PROG;
  endproperty
  a_byp_setup: assert property (p_byp_setup) else $error("bypass program setup code wrong");

  property p_hv_prot;
    !pins_r.we_n && op_r == OP_PROTECT |-> hv_en_r && pins_r.dq_o == CMD_PROTECT;
  endproperty
  a_hv_prot: assert property (p_hv_prot) else $error("protect write without high voltage");

  property p_verify_bit;
    $rose(prot_ok_r) |-> $past(brd[0]) && $past(ph_r) == PH_VERIFY;
  endproperty
  a_verify_bit: assert property (p_verify_bit) else $error("protect ok without bit 0");

  property p_hv_release;
    $fell(busy_r) && op_r == OP_PROTECT |-> !hv_en_r;
  endproperty
  a_hv_release: assert property (p_hv_release) else $error("high voltage held after protect");

  property p_poll_addr;
    req_v_r && (ph_r == PH_POLL1 || ph_r == PH_POLL2) |-> !req_r.we && req_r.addr == addr_r;
  endproperty
  a_poll_addr: assert property (p_poll_addr) else $error("poll at wrong address");

  property p_data_late;
    $changed(rdata_r) |-> $past(ph_r) == PH_FINAL;
  endproperty
  a_data_late: assert property (p_data_late) else $error("data taken from status read");

  property p_fail_reset;
    fail_set && ph_r == PH_POLL2 |=> req_r.data == CMD_RESET && req_r.we ##1 req_v_r;
  endproperty
  a_fail_reset: assert property (p_fail_reset) else $error("no reset after failure");

  c_byp_prog: cover property (seq_end && op_r == OP_PROG && bypass_r);
  c_prot_ok:  cover property ($rose(prot_ok_r));
  c_fail:     cover property ($rose(fail_r));
  c_erase:    cover property (seq_end && op_r == OP_SECT_ERASE);
endmodule // fsb_host

/* common/fsb_pkg.sv */
// constants and carrier types for the flash status and bypass program controller
package fsb_pkg;
  localparam int ADDR_W       = 20;
  localparam int PADDR_W      = 8;
  localparam int CLK_NS       = 10;
  localparam int SYNC_STAGES  = 2;
  localparam int ACC_NS       = 70;
  localparam int WR_PULSE_NS  = 35;
  localparam int RD_PULSE_CYC = (ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES + 1;
  localparam int WR_PULSE_CYC = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOVER_CYC  = 2;
  localparam int PROT_US      = 250;
  localparam int PROT_CYC     = (PROT_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int PROT_TRIES   = 25;

  localparam logic [7:0]  CMD_PROG    = 8'ha0;
  localparam logic [7:0]  CMD_PROTECT = 8'h60;
  // a6, a1, a0 = 0, 1, 0 with the other low address pins held low
  localparam logic [11:0] PROT_LOW    = 12'h002;

  localparam logic [PADDR_W-1:0] REG_CMD    = 8'h00;
  localparam logic [PADDR_W-1:0] REG_ADDR   = 8'h04;
  localparam logic [PADDR_W-1:0] REG_WDATA  = 8'h08;
  localparam logic [PADDR_W-1:0] REG_STATUS = 8'h0c;
  localparam logic [PADDR_W-1:0] REG_RDATA  = 8'h10;

  localparam int ST_BUSY = 0;
  localparam int ST_BYP  = 1;
  localparam int ST_FAIL = 2;
  localparam int ST_REF  = 3;
  localparam int ST_OK   = 4;
  localparam int ST_HV   = 5;
  localparam int ST_LAST = 8;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_READ = 4'h1, OP_WRITE = 4'h2, OP_PROG = 4'h3,
    OP_BYP_ENTER = 4'h4, OP_BYP_EXIT = 4'h5, OP_SECT_ERASE = 4'h6,
    OP_CHIP_ERASE = 4'h7, OP_PROTECT = 4'h8, OP_RESET = 4'h9
  } fsb_op_e;

  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } fsb_req_s;

  typedef struct packed {
    logic              ce_n;
    logic              oe_n;
    logic              we_n;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        dq_o;
    logic              dq_oe;
  } fsb_pins_s;

  localparam fsb_pins_s PINS_IDLE = '{1'b1, 1'b1, 1'b1, 20'h00000, 8'h00, 1'b0};
endpackage

/* verilog/fsb_bus_cycle.sv */
// one asynchronous flash read or write cycle on the parallel pins
`timescale 1ns/100ps
module fsb_bus_cycle #(
  parameter int RD_PULSE = fsb_pkg::RD_PULSE_CYC,
  parameter int WR_PULSE = fsb_pkg::WR_PULSE_CYC,
  parameter int RECOVER  = fsb_pkg::RECOVER_CYC
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // request from the sequencer
  input  wire logic              req_valid,
  input  wire fsb_pkg::fsb_req_s req,
  output logic                   done_r,
  output logic [7:0]             rdata_r,
  // flash pins
  output fsb_pkg::fsb_pins_s     pins_r,
  input  wire logic [7:0]        dq_i
);
  import fsb_pkg::*;

  typedef enum logic [1:0] {B_IDLE = 2'b00, B_SETUP = 2'b01, B_PULSE = 2'b10, B_HOLD = 2'b11} fsb_bst_e;

  fsb_bst_e   bst_r;
  logic [7:0] cnt_r;
  logic       we_r;
  logic [7:0] dq_m_r;
  logic [7:0] dq_s_r;

  // pins are asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dq_m_r <= 8'h00;
      dq_s_r <= 8'h00;
    end
    else
    begin
      dq_m_r <= dq_i;
      dq_s_r <= dq_m_r;
    end
  end

  // ce and oe return high between reads so each read is a fresh access for the toggle bits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bst_r   <= B_IDLE;
      cnt_r   <= 8'h00;
      we_r    <= 1'b0;
      done_r  <= 1'b0;
      rdata_r <= 8'h00;
      pins_r  <= PINS_IDLE;
    end
    else
    begin
      done_r <= 1'b0;
      case (bst_r)
        B_IDLE:
          if (req_valid)
          begin
            pins_r.ce_n  <= 1'b0;
            pins_r.addr  <= req.addr;
            pins_r.dq_o  <= req.data;
            pins_r.dq_oe <= req.we;
            we_r         <= req.we;
            bst_r        <= B_SETUP;
          end
        B_SETUP:
        begin
          pins_r.we_n <= !we_r;
          pins_r.oe_n <= we_r;
          cnt_r       <= we_r ? 8'(WR_PULSE) : 8'(RD_PULSE);
          bst_r       <= B_PULSE;
        end
        B_PULSE:
          if (cnt_r == 8'h01)
          begin
            pins_r.we_n <= 1'b1;
            pins_r.oe_n <= 1'b1;
            pins_r.ce_n <= 1'b1;
            if (!we_r)
              rdata_r <= dq_s_r;
            cnt_r <= 8'(RECOVER);
            bst_r <= B_HOLD;
          end
          else
            cnt_r <= cnt_r - 8'h01;
        B_HOLD:
          if (cnt_r == 8'h01)
          begin
            pins_r.dq_oe <= 1'b0;
            done_r       <= 1'b1;
            bst_r        <= B_IDLE;
          end
          else
            cnt_r <= cnt_r - 8'h01;
        default:
          bst_r <= B_IDLE;
      endcase
    end
  end
endmodule // fsb_bus_cycle

/* tb/fsb_flash_model.sv */
// behavioural flash device answering the controller's pins
`timescale 1ns/100ps
module fsb_flash_model
  import fsb_pkg::*;
(
  // pins from the controller
  input  wire fsb_pins_s pins,
  input  wire logic      hv,
  // data lines back
  output logic [7:0]     dq
);
  logic [7:0] mem [int];
  logic       prot [int];
  logic [7:0] rd;
  logic [7:0] rd_q;
  logic       byp;
  logic       pgm;
  logic       last7;
  logic       tog;
  logic       bad;
  logic       esu;
  logic       ers;
  logic [7:0] old;
  int         step;
  int         busy;
  int         wcnt;
  initial
  begin
    {byp, pgm, last7, tog, rd_q, bad, esu, ers} = '0;
    {step, busy, wcnt} = '0;
  end
  // commands latch on the rising write strobe
  always @(posedge pins.we_n)
  begin
    wcnt++;
    if (hv)
    begin
      if (pins.dq_o == CMD_PROTECT && pins.addr[11:0] == PROT_LOW) prot[int'(pins.addr[19:12])] = 1'b1;
    end
    else if (pgm)
    begin
      // a written 0 never returns to 1; asking for it locks the program
      old = mem.exists(int'(pins.addr)) ? mem[int'(pins.addr)] : 8'hff;
      bad = (old & pins.dq_o) != pins.dq_o;
      if (!bad && !prot.exists(int'(pins.addr[19:12])))
        mem[int'(pins.addr)] = pins.dq_o;
      last7 = pins.dq_o[7];
      busy = 3;
      ers = 1'b0;
      pgm = 1'b0;
    end
    else if (pins.dq_o == 8'hf0)
    begin
      bad = 1'b0;
      busy = 0;
    end
    else if (pins.dq_o == CMD_PROG && (byp || step == 2)) pgm = 1'b1;
    else if (byp && pins.dq_o == 8'h00) byp = 1'b0;
    else if (step == 2 && pins.dq_o == 8'h20) byp = 1'b1;
    else if (esu && step == 2 && pins.dq_o == 8'h30)
    begin
      // protected sectors keep their data
      if (!prot.exists(int'(pins.addr[19:12])))
        for (int i = 0; i < 4096; i++)
          mem.delete(int'(pins.addr[19:12]) * 4096 + i);
      ers = 1'b1;
      busy = 4;
    end
    esu = (step == 2 && pins.dq_o == 8'h80) || esu && step < 2 && (pins.dq_o == 8'haa || pins.dq_o == 8'h55);
    step = (pins.dq_o == 8'haa) ? 1 : (step == 1 && pins.dq_o == 8'h55) ? 2 : 0;
  end
  always @*
  begin
    if (hv) rd = {7'h00, prot.exists(int'(pins.addr[19:12])) != 0};
    else if (busy > 0 && ers) rd = {1'b0, tog, 3'b001, tog, 2'b00};
    else if (busy > 0) rd = {~last7, tog, bad, 3'b001, 2'b00};
    else rd = mem.exists(int'(pins.addr)) ? mem[int'(pins.addr)] : 8'hff;
    // a released bus never shows the last value
    dq = (!pins.ce_n && !pins.oe_n) ? rd : ~rd_q;
  end
  always @(posedge pins.oe_n)
  begin
    rd_q = rd;
    if (busy > 0)
    begin
      tog = ~tog;
      if (!bad)
        busy--;
    end
  end
endmodule // fsb_flash_model

/* tb/flash_status_and_bypass_program_test.sv */
// self-checking bench for the flash status and bypass program controller
`timescale 1ns/100ps
module flash_status_and_bypass_program_test;
  import fsb_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic [7:0]  paddr = 0, dq, d;
  logic [31:0] pwdata = 0, prdata_r, r;
  logic        pready_r, pslverr_r, hv_en_r;
  logic [19:0] a;
  fsb_pins_s   pins_r;
  int          fails = 0, check_count = 0, w0, k;
  always #5 pclk = ~pclk;
  fsb_host #(.PROT_CYC(20), .PROT_TRIES(3)) i_fsb_host (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata_r, .pready_r, .pslverr_r, .pins_r, .dq_i(dq), .hv_en_r);
  fsb_flash_model i_fsb_flash_model (.pins(pins_r), .hv(hv_en_r), .dq);
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, ad, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready_r !== 1'b1 && ++n < 20);
    if (n == 20)
    begin
      fails++;
      give_verdict;
    end
    r = prdata_r;
    e = pslverr_r;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task op(input logic [3:0] o, input logic [19:0] ad, input logic [7:0] wd);
    apb(1, REG_ADDR, {12'h000, ad});
    apb(1, REG_WDATA, {24'h000000, wd});
    apb(1, REG_CMD, {28'h0000000, o});
    for (k = 0; k < 400; k++)
    begin
      apb(0, REG_STATUS, 0);
      if (r[ST_BUSY] === 1'b0) break;
    end
    if (k == 400)
    begin
      fails++;
      give_verdict;
    end
  endtask
  initial
  begin
    void'($urandom(32'hc6ad));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, REG_STATUS, 0);
    chk(r, 0, "status after reset");
    apb(0, 8'h40, 0);
    chk(e, 1, "unmapped access");
    $display("test reset done");
    // first a normal program, then one in bypass
    for (int m = 0; m < 2; m++)
    begin
      a = $urandom;
      // never all ones, so a later 8'hff program is a non-blank write
      d = $urandom % 255;
      w0 = i_fsb_flash_model.wcnt;
      op(OP_PROG, a, d);
      chk(i_fsb_flash_model.wcnt - w0, m ? 2 : 4, "write cycles");
      op(OP_READ, a, 0);
      apb(0, REG_RDATA, 0);
      chk(r, {24'h000000, d}, "read back");
      if (m == 0) op(OP_BYP_ENTER, 0, 0);
      apb(0, REG_STATUS, 0);
      chk(r[ST_BYP], 1, "bypass held");
    end
    $display("test program done");
    w0 = i_fsb_flash_model.wcnt;
    op(OP_SECT_ERASE, a, 0);
    apb(0, REG_STATUS, 0);
    chk(r[ST_REF], 1, "erase in bypass refused");
    chk(i_fsb_flash_model.wcnt - w0, 0, "erase in bypass pins");
    op(OP_BYP_EXIT, 0, 0);
    apb(0, REG_STATUS, 0);
    chk({r[ST_BYP], i_fsb_flash_model.byp}, 0, "bypass exit");
    op(OP_PROG, a, 8'hff);
    apb(0, REG_STATUS, 0);
    chk({r[ST_FAIL], r[15], r[13], i_fsb_flash_model.bad}, 4'b1010, "locked program");
    w0 = i_fsb_flash_model.wcnt;
    op(OP_SECT_ERASE, a, 0);
    chk(i_fsb_flash_model.wcnt - w0, 6, "erase cycles");
    apb(0, REG_RDATA, 0);
    chk(r, 32'h000000ff, "erased read");
    $display("test status done");
    op(OP_BYP_ENTER, 0, 0);
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, REG_STATUS, 0);
    chk(r[ST_BYP], 0, "bypass after reset");
    $display("test bypass done");
    a = $urandom;
    op(OP_PROTECT, a, 0);
    apb(0, REG_STATUS, 0);
    chk({r[ST_OK], r[ST_FAIL], hv_en_r}, 3'b100, "protect result");
    chk(i_fsb_flash_model.prot.exists(int'(a[19:12])), 1, "sector protected");
    $display("test protect done");
    give_verdict;
  end
endmodule // flash_status_and_bypass_program_test
